/* File: bench/spse_board.sv */
// Board and probe model: resolves the shared pads and the reset pin
module spse_board (
    input  wire logic [6:0] padOut,
    input  wire logic [6:0] padOe,
    input  wire logic [5:0] probeLines,
    input  wire logic       eraseHold,
    input  wire logic       externalPull,
    input  wire logic       externalResetOut,
    input  wire logic       externalResetOe,
    output logic      [6:0] padIn,
    output logic            externalResetIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Pad resolution
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            padIn[i] = padOe[i] ? padOut[i] : probeLines[i];
        end
        // Pull-down keeps the erase pin low unless the board holds it
        padIn[6] = padOe[6] ? padOut[6] : eraseHold;
        // Pull-up on the reset pin when nobody pulls it low
        externalResetIn = externalResetOe ? externalResetOut : !externalPull;
    end
endmodule // spse_board

/* File: bench/spse_monitor.sv */
// Assertion checker for the system pin select block
module spse_monitor #(
    parameter int SLOW_DIV = 2
) (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic [6:0] padIn,
    input wire logic       boundaryScanSelectPin,
    input wire logic       boundaryScanMode,
    input wire logic       testModePin,
    input wire logic       testModeActive,
    input wire logic       externalResetIn,
    input wire logic       externalResetOut,
    input wire logic       externalResetOe,
    input wire logic       resetControllerAssert,
    input wire logic       coreReset,
    input wire logic       flashEraseRequest
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    // Counters stand in for long repetitions the tools cannot unroll
    localparam int IgnoreCycles = 3276 * SLOW_DIV;
    int oeCnt;
    int highCnt;
    int next_oeCnt;
    int next_highCnt;
    always_comb begin
        next_oeCnt = externalResetOe ? oeCnt + 1 : 0;
        next_highCnt = padIn[6] ? highCnt + 1 : 0;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            oeCnt <= 0;
            highCnt <= 0;
        end else begin
            oeCnt <= next_oeCnt;
            highCnt <= next_highCnt;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_scan_follows_pin: assert property (boundaryScanMode == boundaryScanSelectPin)
        else $error("scan mode differs from its select pin");
    a_test_follows_pin: assert property (testModeActive == testModePin)
        else $error("test mode differs from its pin");
    a_reset_drives_low: assert property (externalResetOe |-> !externalResetOut)
        else $error("reset pin driven high");
    a_reset_drive_cause: assert property ($rose(externalResetOe) |-> $past(resetControllerAssert))
        else $error("reset pin driven without a request");
    a_reset_min_pulse: assert property ($fell(externalResetOe) |-> oeCnt >= 40)
        else $error("driven reset pulse too short");
    a_core_from_pin: assert property (!externalResetIn || externalResetOe |-> coreReset)
        else $error("core not reset while pin low");
    a_erase_one_cycle: assert property (flashEraseRequest |=> !flashEraseRequest)
        else $error("erase request longer than one cycle");
    a_erase_needs_hold: assert property (flashEraseRequest |-> highCnt >= IgnoreCycles)
        else $error("erase after too short a high level");
endmodule // spse_monitor

bind spse_pin_select spse_monitor #(.SLOW_DIV(SLOW_DIV)) mon_u (
    .clock, .rst_n, .padIn, .boundaryScanSelectPin, .boundaryScanMode, .testModePin,
    .testModeActive, .externalResetIn, .externalResetOut, .externalResetOe,
    .resetControllerAssert, .coreReset, .flashEraseRequest
);

/* File: bench/tb.sv */
// Self-checking testbench of the system pin select block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals, models and tasks
    // ------------------------------------------------------------
    // Short slow-clock divider keeps the erase windows affordable
    localparam int SD = 2;
    logic clock, rst_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [6:0] padIn, padOut, padOe, gpioIn, gpioOut, gpioOe;
    logic debugClk, debugModeIn, debugModeOut, debugModeOe, debugIn, debugOutData, debugOutOe;
    logic asyncTraceOutput, serialWireActive, usbDataMinusIn, usbDataPlusIn;
    logic usbDataMinusOut, usbDataPlusOut, usbOe, boundaryScanSelectPin, testModePin;
    logic boundaryScanMode, testModeActive, externalResetIn, externalResetOut;
    logic externalResetOe, resetControllerAssert, coreReset, flashEraseRequest;
    logic [3:0] crystalOscSel;
    logic [5:0] probeLines;
    logic eraseHold, externalPull;
    int miscompares, n_compared, at, n;
    assign hready = hreadyout;
    spse_pin_select #(.SLOW_DIV(SD)) dut_u (
        .clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata,
        .hreadyout, .hresp, .padIn, .padOut, .padOe, .gpioIn, .gpioOut, .gpioOe, .debugClk,
        .debugModeIn, .debugModeOut, .debugModeOe, .debugIn, .debugOutData, .debugOutOe,
        .asyncTraceOutput, .serialWireActive, .usbDataMinusIn, .usbDataPlusIn,
        .usbDataMinusOut, .usbDataPlusOut, .usbOe, .crystalOscSel, .boundaryScanSelectPin,
        .testModePin, .boundaryScanMode, .testModeActive, .externalResetIn,
        .externalResetOut, .externalResetOe, .resetControllerAssert, .coreReset,
        .flashEraseRequest);
    spse_board board_u (.padOut, .padOe, .probeLines, .eraseHold, .externalPull,
        .externalResetOut, .externalResetOe, .padIn, .externalResetIn);
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic report_and_stop();
        if (miscompares == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
    endtask
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (hready !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
    endtask
    // Single word transfer; read data is taken at the closing edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask
    task automatic watch(input int len);
        at = -1;
        for (int i = 1; i <= len; i++) begin
            @(posedge clock);
            if (flashEraseRequest === 1'b1 && at < 0)
                at = i;
        end
    endtask
    task automatic t_defaults();
        bus(1'b0, 32'h00, 32'h0); check(q, 32'h0);
        bus(1'b0, 32'h04, 32'h0); check(q, 32'h0);
        bus(1'b0, 32'h40, 32'h0); check(q, 32'h0);
        cyc(2);
        check({usbDataPlusIn, usbDataMinusIn, debugClk, debugModeIn, debugIn}, 5'h05);
        check(padOe, 7'h32);
        check(gpioIn, 7'h0B);
        check({hresp, hreadyout}, 2'b01);
    endtask
    task automatic t_gpio();
        bus(1'b1, 32'h00, 32'h1CF0);
        bus(1'b0, 32'h00, 32'h0); check(q, 32'h1CF0);
        gpioOe <= 7'h02;
        cyc(2);
        check(padOe, 7'h02);
        check(padOut[1], 1'b0);
        check({usbDataPlusIn, usbDataMinusIn, debugClk, debugModeIn, debugIn}, 5'h02);
        check(gpioIn, 7'h39);
        bus(1'b1, 32'h00, 32'h0);
        cyc(1);
        check(padOe, 7'h32);
        gpioOe <= 7'h00;
    endtask
    task automatic t_misc();
        cyc(1);
        check(padOut[1], 1'b1);
        serialWireActive <= 1'b1;
        cyc(2);
        check({padOe[1], padOut[1]}, 2'b10);
        serialWireActive <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            {boundaryScanSelectPin, testModePin} <= i[1:0];
            cyc(2);
            check({boundaryScanMode, testModeActive}, i[1:0]);
        end
        bus(1'b1, 32'h04, 32'hF);
        cyc(1);
        check(crystalOscSel, 4'hF);
        bus(1'b1, 32'h04, 32'h0);
    endtask
    task automatic t_reset_pin();
        resetControllerAssert <= 1'b1;
        cyc(1);
        resetControllerAssert <= 1'b0;
        for (n = 0; externalResetOe !== 1'b1 && n < 5; n++)
            cyc(1);
        check({coreReset, externalResetIn}, 2'b10);
        for (n = 0; externalResetOe === 1'b1 && n < 200; n++)
            cyc(1);
        check(n >= 40 && n < 200, 1'b1);
        externalPull <= 1'b1;
        cyc(2);
        check({coreReset, externalResetOe}, 2'b10);
        externalPull <= 1'b0;
        cyc(2);
        check({coreReset, externalResetOe}, 2'b00);
    endtask
    task automatic t_erase();
        eraseHold <= 1'b1;
        watch(3000 * SD);
        check(at, -1);
        eraseHold <= 1'b0;
        watch(100);
        check(at, -1);
        eraseHold <= 1'b1;
        watch(7500 * SD);
        eraseHold <= 1'b0;
        check(at >= 7208 * SD, 1'b1);
        bus(1'b0, 32'h0C, 32'h0); check(q[0], 1'b1);
        bus(1'b1, 32'h0C, 32'h1);
        bus(1'b0, 32'h0C, 32'h0);
        check(q[0], 1'b0);
        bus(1'b1, 32'h00, 32'h1000);
        gpioOe <= 7'h40;
        gpioOut <= 7'h40;
        watch(7500 * SD);
        check(at, -1);
        gpioOe <= 7'h00;
        gpioOut <= 7'h00;
        bus(1'b1, 32'h00, 32'h0);
    endtask
    initial begin
        {rst_n, hsel, hwrite, htrans, hsize, haddr, hwdata, gpioOut, gpioOe} = '0;
        {debugModeOut, debugModeOe, asyncTraceOutput, serialWireActive, usbOe} = 5'h01;
        {usbDataMinusOut, usbDataPlusOut, debugOutData, debugOutOe} = 4'h3;
        {boundaryScanSelectPin, testModePin, resetControllerAssert} = 3'h0;
        {eraseHold, externalPull, miscompares, n_compared} = '0;
        probeLines = 6'h3B;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        cyc(1);
        t_defaults();
        t_gpio();
        t_misc();
        t_reset_pin();
        t_erase();
        report_and_stop();
    end
endmodule // tb

/* File: rtl/spse_pin_select.sv */
// Pin select, debug port pins, external reset pin and flash-clear detector
//
// What this block does
// - After reset every shared pin is in its default function; software may reassign.
// - Select bit 12 picks flash-clear function or port_b_line_twelve.
// - Select bits 10 and 11 pick USB data pins or port B lines ten, eleven.
// - Select bits 7 to 4 pick debug pins or port B lines seven to four.
// - Debug pins start in debug port mode so a probe connects without software.
// - Pad settings apply in both system and general I/O mode.
// - High boundary-scan select pin selects boundary scan; low is normal operation.
// - Trace drives the debug out pin only while serial-wire port is active.
// - Asserted test-mode pin selects scan test or fast programming; low is inactive.
// - External reset pin is bidirectional: driven low by device or pulled externally.
// - Low external reset resets core and peripherals but not the backup domain.
// - Any external reset length is accepted; device-driven pulses have a minimum length.
// - External reset pin is an input out of reset until the controller asserts it.
// - A valid flash-clear request erases flash and some configuration bits to ones.
// - Flash-clear input is debounced on the slow clock.
// - Flash-clear high for under 100 ms is ignored.
// - Flash-clear high for over 220 ms performs the erase.
// - Flash-clear starts as system function; driving it as output never erases.
// - Crystal pins default to general I/O lines, oscillator is the alternate.
`include "spse_regs.svh"

module spse_pin_select #(
    parameter int SLOW_DIV = `SPSE_SYNC_CLK_HZ / `SPSE_SLOW_CLK_HZ
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Shared pads: index 0..6 = B4,B5,B6,B7,B10,B11,B12
    input  wire logic [6:0]  padIn,
    output logic      [6:0]  padOut,
    output logic      [6:0]  padOe,
    // General I/O controller side of the same pads
    output logic      [6:0]  gpioIn,
    input  wire logic [6:0]  gpioOut,
    input  wire logic [6:0]  gpioOe,
    // Debug port side
    output logic             debugClk,
    output logic             debugModeIn,
    input  wire logic        debugModeOut,
    input  wire logic        debugModeOe,
    output logic             debugIn,
    input  wire logic        debugOutData,
    input  wire logic        debugOutOe,
    input  wire logic        asyncTraceOutput,
    input  wire logic        serialWireActive,
    // USB transceiver side
    output logic             usbDataMinusIn,
    output logic             usbDataPlusIn,
    input  wire logic        usbDataMinusOut,
    input  wire logic        usbDataPlusOut,
    input  wire logic        usbOe,
    // Crystal pins
    output logic      [3:0]  crystalOscSel,
    // Mode pins
    input  wire logic        boundaryScanSelectPin,
    input  wire logic        testModePin,
    output logic             boundaryScanMode,
    output logic             testModeActive,
    // External reset pin
    input  wire logic        externalResetIn,
    output logic             externalResetOut,
    output logic             externalResetOe,
    input  wire logic        resetControllerAssert,
    output logic             coreReset,
    // Flash clear
    output logic             flashEraseRequest
);

    // ------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------
    localparam int IGNORE_TICKS = `SPSE_SLOW_CLK_HZ * `SPSE_IGNORE_MS / 1000;
    localparam int ERASE_TICKS  = (`SPSE_SLOW_CLK_HZ * `SPSE_ERASE_MS + 999) / 1000 + 1;
    localparam int RST_CYCLES   = `SPSE_RST_PULSE_CYCLES;
    localparam logic [31:0] SEL_MASK =
        (32'h1 << `SPSE_BIT_DEBUG_IN) |
        (32'h1 << `SPSE_BIT_DEBUG_OUT) |
        (32'h1 << `SPSE_BIT_DEBUG_MODE) |
        (32'h1 << `SPSE_BIT_DEBUG_CLK) |
        (32'h1 << `SPSE_BIT_USB_MINUS) |
        (32'h1 << `SPSE_BIT_USB_PLUS) |
        (32'h1 << `SPSE_BIT_FLASH_CLEAR);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // Counters are 16 bits; a longer window would wrap and never fire
    initial begin
        if (SLOW_DIV < 2) begin
            $error("SLOW_DIV must be at least 2");
        end
        if (SLOW_DIV > 65536) begin
            $error("SLOW_DIV must fit the divider");
        end
        if (IGNORE_TICKS < 1) begin
            $error("ignore window must be at least one tick");
        end
        if (ERASE_TICKS > 65535) begin
            $error("erase window must fit the press counter");
        end
        if (RST_CYCLES < 1 || RST_CYCLES > 65536) begin
            $error("reset pulse must fit its counter");
        end
        if (`SPSE_SYSIO_MASK != SEL_MASK) begin
            $error("select mask disagrees with the select bits");
        end
        if ((`SPSE_SYSIO_RESET & ~`SPSE_SYSIO_MASK) != 32'h00000000) begin
            $error("select reset value sets unused bits");
        end
        if ((`SPSE_XTAL_RESET & ~`SPSE_XTAL_MASK) != 32'h00000000) begin
            $error("crystal reset value sets unused bits");
        end
    end

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic [31:0] sysioSel;
    logic [31:0] next_sysioSel;
    logic [3:0]  xtalSel;
    logic [3:0]  next_xtalSel;
    logic        wrPend;
    logic        next_wrPend;
    logic [7:0]  wrAddr;
    logic [7:0]  next_wrAddr;
    logic [31:0] next_hrdata;
    logic        eraseDone;
    logic        next_eraseDone;
    logic        eraseClr;
    logic        accept;
    logic        flashClearSync;
    logic [31:0] statusWord;

    assign accept    = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    always_comb begin
        next_sysioSel = sysioSel;
        next_xtalSel  = xtalSel;
        next_wrPend   = accept && hwrite;
        next_wrAddr   = accept ? haddr[7:0] : wrAddr;
        next_hrdata   = hrdata;
        eraseClr      = 1'b0;
        if (wrPend) begin
            case (wrAddr)
                `SPSE_SYSIO_OFFSET: next_sysioSel = hwdata & `SPSE_SYSIO_MASK;
                `SPSE_XTAL_OFFSET:  next_xtalSel  = 4'(hwdata & `SPSE_XTAL_MASK);
                `SPSE_STATUS_OFFSET: eraseClr     = hwdata[0];
                default: ;
            endcase
        end
        if (accept && !hwrite) begin
            case (haddr[7:0])
                `SPSE_SYSIO_OFFSET:  next_hrdata = sysioSel;
                `SPSE_XTAL_OFFSET:   next_hrdata = {28'h0000000, xtalSel};
                `SPSE_STATUS_OFFSET: next_hrdata = statusWord;
                default:             next_hrdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sysioSel <= `SPSE_SYSIO_RESET;
            xtalSel  <= 4'(`SPSE_XTAL_RESET);
            wrPend   <= 1'b0;
            wrAddr   <= 8'h00;
            hrdata   <= 32'h00000000;
        end else begin
            sysioSel <= next_sysioSel;
            xtalSel  <= next_xtalSel;
            wrPend   <= next_wrPend;
            wrAddr   <= next_wrAddr;
            hrdata   <= next_hrdata;
        end
    end

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    // Live levels and the sticky erase flag, taken on the read address phase like any register
    assign statusWord = {26'h0, serialWireActive, boundaryScanMode, testModeActive,
                         externalResetIn, flashClearSync, eraseDone};

    // ------------------------------------------------------------------
    // Pad multiplexing
    // ------------------------------------------------------------------
    logic [6:0] gpioMode;
    logic [6:0] sysOut;
    logic [6:0] sysOe;

    assign gpioMode = {sysioSel[`SPSE_BIT_FLASH_CLEAR], sysioSel[`SPSE_BIT_USB_PLUS],
                       sysioSel[`SPSE_BIT_USB_MINUS], sysioSel[`SPSE_BIT_DEBUG_CLK],
                       sysioSel[`SPSE_BIT_DEBUG_MODE], sysioSel[`SPSE_BIT_DEBUG_OUT],
                       sysioSel[`SPSE_BIT_DEBUG_IN]};

    // Trace only replaces scan data while serial wire is up
    always_comb begin
        sysOut    = 7'h00;
        sysOe     = 7'h00;
        sysOut[1] = serialWireActive ? asyncTraceOutput : debugOutData;
        sysOe[1]  = serialWireActive ? 1'b1 : debugOutOe;
        sysOut[2] = debugModeOut;
        sysOe[2]  = debugModeOe;
        sysOut[4] = usbDataMinusOut;
        sysOe[4]  = usbOe;
        sysOut[5] = usbDataPlusOut;
        sysOe[5]  = usbOe;
    end

    // Pad settings live in the I/O controller and act in both modes
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_pad
            assign padOut[gi] = gpioMode[gi] ? gpioOut[gi] : sysOut[gi];
            assign padOe[gi]  = gpioMode[gi] ? gpioOe[gi]  : sysOe[gi];
            assign gpioIn[gi] = padIn[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // System-side inputs
    // ------------------------------------------------------------------
    // Inactive levels keep debug and USB logic quiet in I/O mode
    assign debugIn        = gpioMode[0] ? 1'b0 : padIn[0];
    assign debugModeIn    = gpioMode[2] ? 1'b1 : padIn[2];
    assign debugClk       = gpioMode[3] ? 1'b0 : padIn[3];
    assign usbDataMinusIn = gpioMode[4] ? 1'b0 : padIn[4];
    assign usbDataPlusIn  = gpioMode[5] ? 1'b0 : padIn[5];

    // ------------------------------------------------------------------
    // Crystal pins
    // ------------------------------------------------------------------
    assign crystalOscSel  = xtalSel;

    // ------------------------------------------------------------------
    // Mode pins
    // ------------------------------------------------------------------
    assign boundaryScanMode = boundaryScanSelectPin;
    assign testModeActive   = testModePin;

    // ------------------------------------------------------------------
    // External reset pin
    // ------------------------------------------------------------------
    spse_pkg::spse_rst_state_t rstState;
    spse_pkg::spse_rst_state_t next_rstState;
    logic [15:0] rstCnt;
    logic [15:0] next_rstCnt;

    always_comb begin
        next_rstState = rstState;
        next_rstCnt   = rstCnt;
        case (rstState)
            spse_pkg::SPSE_RST_IDLE: begin
                if (resetControllerAssert) begin
                    next_rstState = spse_pkg::SPSE_RST_DRIVE;
                    next_rstCnt   = 16'(RST_CYCLES - 1);
                end
            end
            spse_pkg::SPSE_RST_DRIVE: begin
                if (rstCnt != 16'h0000) begin
                    next_rstCnt = rstCnt - 16'h0001;
                end else if (!resetControllerAssert) begin
                    next_rstState = spse_pkg::SPSE_RST_RELEASE;
                end
            end
            // One idle cycle lets the pull-up restore the pin before a new drive
            spse_pkg::SPSE_RST_RELEASE: next_rstState = spse_pkg::SPSE_RST_IDLE;
            default: next_rstState = spse_pkg::SPSE_RST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstState <= spse_pkg::SPSE_RST_IDLE;
            rstCnt   <= 16'h0000;
        end else begin
            rstState <= next_rstState;
            rstCnt   <= next_rstCnt;
        end
    end

    assign externalResetOut = 1'b0;
    assign externalResetOe  = (rstState == spse_pkg::SPSE_RST_DRIVE);

    // ------------------------------------------------------------------
    // Core reset
    // ------------------------------------------------------------------
    // Any low level, however short, resets; backup domain not wired here
    assign coreReset        = !externalResetIn || externalResetOe;

    // ------------------------------------------------------------------
    // Flash clear detector on slow clock tick
    // ------------------------------------------------------------------
    logic [15:0] divCnt;
    logic [15:0] next_divCnt;
    logic        slowTick;
    logic        flashClearRaw;
    logic        next_flashClearSync;
    logic [15:0] highTicks;
    logic [15:0] next_highTicks;

    // Free-running divider: a press is seen within one tick of its start
    assign slowTick      = (divCnt == 16'(SLOW_DIV - 1));
    // Output mode never feeds the detector
    assign flashClearRaw = gpioMode[6] ? 1'b0 : padIn[6];

    always_comb begin
        next_divCnt         = slowTick ? 16'h0000 : divCnt + 16'h0001;
        next_flashClearSync = slowTick ? flashClearRaw : flashClearSync;
        next_highTicks      = highTicks;
        next_eraseDone      = eraseDone;
        if (slowTick) begin
            if (!flashClearSync) begin
                next_highTicks = 16'h0000;
            end else if (highTicks != 16'(ERASE_TICKS)) begin
                next_highTicks = highTicks + 16'h0001;
            end
        end
        if (eraseClr) begin
            next_eraseDone = 1'b0;
        end
        if (flashEraseRequest) begin
            next_eraseDone = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            divCnt         <= 16'h0000;
            flashClearSync <= 1'b0;
            highTicks      <= 16'h0000;
            eraseDone      <= 1'b0;
        end else begin
            divCnt         <= next_divCnt;
            flashClearSync <= next_flashClearSync;
            highTicks      <= next_highTicks;
            eraseDone      <= next_eraseDone;
        end
    end

    // ------------------------------------------------------------------
    // Erase request
    // ------------------------------------------------------------------
    // One pulse once the high time passes the erase window
    assign flashEraseRequest = slowTick && flashClearSync &&
                               (highTicks == 16'(ERASE_TICKS - 1));

    initial begin
        if (IGNORE_TICKS >= ERASE_TICKS) begin
            $error("ignore window must be shorter than erase window");
        end
    end

endmodule // spse_pin_select

/* File: rtl/spse_pkg.sv */
// Types of the system pin select and erase detect block
package spse_pkg;

    typedef enum logic [1:0] {
        SPSE_DP_SCAN,
        SPSE_DP_SERIAL
    } spse_dp_mode_t;

    typedef enum {
        SPSE_RST_IDLE,
        SPSE_RST_DRIVE,
        SPSE_RST_RELEASE
    } spse_rst_state_t;

    typedef struct packed {
        logic in;
        logic out;
        logic oe;
    } spse_pad_t;

    typedef struct packed {
        logic [31:0] haddr;
        logic        hwrite;
        logic        sel;
    } spse_bus_req_t;

endpackage

/* File: rtl/spse_regs.svh */
// Register offsets, field positions, reset values and timing counts of the pin select block
`ifndef SPSE_REGS_SVH
`define SPSE_REGS_SVH

// ------------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------------
`define SPSE_SYSIO_OFFSET       8'h00
`define SPSE_XTAL_OFFSET        8'h04
`define SPSE_RSTCTL_OFFSET      8'h08
`define SPSE_STATUS_OFFSET      8'h0C

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define SPSE_BIT_DEBUG_IN       4
`define SPSE_BIT_DEBUG_OUT      5
`define SPSE_BIT_DEBUG_MODE     6
`define SPSE_BIT_DEBUG_CLK      7
`define SPSE_BIT_USB_MINUS      10
`define SPSE_BIT_USB_PLUS       11
`define SPSE_BIT_FLASH_CLEAR    12
`define SPSE_SYSIO_MASK         32'h00001CF0
`define SPSE_XTAL_MASK          32'h0000000F
`define SPSE_SYSIO_RESET        32'h00000000
`define SPSE_XTAL_RESET         32'h00000000

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define SPSE_SLOW_CLK_HZ        32768
`define SPSE_IGNORE_MS          100
`define SPSE_ERASE_MS           220
`define SPSE_SYNC_CLK_HZ        40000000
`define SPSE_CLK_PERIOD_NS      25
`define SPSE_RST_PULSE_NS       1000
`define SPSE_RST_PULSE_CYCLES   ((`SPSE_RST_PULSE_NS + `SPSE_CLK_PERIOD_NS - 1) / `SPSE_CLK_PERIOD_NS)

`endif
